// [hdl/usc_top.sv]
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none
module usc_top
    import usc_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial line
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    output logic serial_tx_oe,
    // Event pulses
    output logic tx_irq_pulse,
    output logic rx_irq_pulse
);
    localparam int CNT_W = $clog2(BIT_CYCLES);
    localparam int QW = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] BIT_END = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] BIT_HALF = CNT_W'(BIT_CYCLES / 2 - 1);
    localparam logic [CNT_W-1:0] IR_LEN = CNT_W'(BIT_CYCLES * IR_NUM / IR_DEN);

    if (BIT_CYCLES < IR_DEN || FIFO_DEPTH < 3) begin : g_chk
        $error("usc_top: BIT_CYCLES or FIFO_DEPTH too small");
    end

    // ****************************************
    // Register bus
    // ****************************************
    logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [1:0] tx_irq_mode_sel_ff, rx_irq_mode_sel_ff, frame_format_select_ff;
    logic tx_polarity_invert_ff, tx_break_request_ff, tx_enable_bit_ff;
    logic address_detect_enable_ff, overrun_error_flag_ff, infrared_codec_enable_ff;
    logic [15:0] status_word, mode_word;
    wire [QW-1:0] tx_count, rx_count;
    wire [8:0] tx_head;
    wire [RXW_W-1:0] rx_head;
    logic tx_shift_empty, rx_idle_flag, brk_done, rx_overrun;

    wire wr_go = s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
    wire rd_go = s_axi_arvalid && !arready_ff && !rvalid_ff;
    wire wr_status = awready_ff && s_axi_awaddr == OFS_STATUS;
    wire wr_mode = awready_ff && s_axi_awaddr == OFS_MODE;
    wire wr_tx = awready_ff && s_axi_awaddr == OFS_TXDATA && s_axi_wstrb[0];
    wire wr_hit = s_axi_awaddr == OFS_STATUS || s_axi_awaddr == OFS_MODE
        || s_axi_awaddr == OFS_TXDATA;
    wire rd_hit = s_axi_araddr == OFS_STATUS || s_axi_araddr == OFS_MODE
        || s_axi_araddr == OFS_RXDATA || s_axi_araddr == OFS_TXDATA;
    wire [15:0] wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [15:0] sw_status = (status_word & ~wmask) | (s_axi_wdata[15:0] & wmask);
    wire [15:0] sw_mode = (mode_word & ~wmask) | (s_axi_wdata[15:0] & wmask);
    wire [31:0] rd_word = (s_axi_araddr == OFS_STATUS) ? {16'h0000, status_word}
        : (s_axi_araddr == OFS_MODE) ? {16'h0000, mode_word}
        : (s_axi_araddr == OFS_RXDATA) ? {23'h000000, rx_head[8:0]}
        : 32'h00000000;

    // Reading received data consumes the head entry
    wire rx_pop = arready_ff && s_axi_araddr == OFS_RXDATA;
    wire tx_full = tx_count == QW'(FIFO_DEPTH);
    wire rx_full = rx_count == QW'(FIFO_DEPTH);
    wire tx_push = wr_tx && tx_enable_bit_ff && !tx_full;
    // A new overrun beats a clear in the same cycle, so no flush then
    wire ovr_clear = wr_status && overrun_error_flag_ff && !sw_status[POS_OVR];
    wire rx_flush = ovr_clear && !rx_overrun;

    // Parity and framing flags of an empty buffer read 0 rather than a stale entry
    assign status_word = {tx_irq_mode_sel_ff[1], tx_polarity_invert_ff,
        tx_irq_mode_sel_ff[0], 1'b0, tx_break_request_ff, tx_enable_bit_ff,
        tx_full, tx_shift_empty, rx_irq_mode_sel_ff, address_detect_enable_ff,
        rx_idle_flag, rx_head[RXW_PARITY_ERROR_FLAG] && rx_count != '0,
        rx_head[RXW_FRAMING_ERROR_FLAG] && rx_count != '0,
        overrun_error_flag_ff, rx_count != '0};
    assign mode_word = (16'(infrared_codec_enable_ff) << POS_IR)
        | (16'(frame_format_select_ff) << POS_FMT_LO);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else begin
            awready_ff <= wr_go;
            arready_ff <= rd_go;
            if (awready_ff) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (arready_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_word;
                rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Control fields
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {tx_irq_mode_sel_ff[1], tx_polarity_invert_ff, tx_irq_mode_sel_ff[0]} <= 3'h0;
            tx_break_request_ff <= STATUS_RESET[POS_BRK];
            tx_enable_bit_ff <= STATUS_RESET[POS_TXEN];
            rx_irq_mode_sel_ff <= STATUS_RESET[POS_RXM_HI:POS_RXM_LO];
            address_detect_enable_ff <= STATUS_RESET[POS_ADET];
            overrun_error_flag_ff <= STATUS_RESET[POS_OVR];
            infrared_codec_enable_ff <= MODE_RESET[POS_IR];
            frame_format_select_ff <= MODE_RESET[POS_FMT_HI:POS_FMT_LO];
        end else begin
            if (wr_status) begin
                tx_irq_mode_sel_ff <= {sw_status[POS_TXM_HI], sw_status[POS_TXM_LO]};
                tx_polarity_invert_ff <= sw_status[POS_TXINV];
                tx_enable_bit_ff <= sw_status[POS_TXEN];
                rx_irq_mode_sel_ff <= sw_status[POS_RXM_HI:POS_RXM_LO];
                address_detect_enable_ff <= sw_status[POS_ADET];
            end
            if (brk_done) begin
                tx_break_request_ff <= 1'b0;
            end else if (wr_status) begin
                tx_break_request_ff <= sw_status[POS_BRK];
            end
            if (rx_overrun) begin
                overrun_error_flag_ff <= 1'b1;
            end else if (ovr_clear) begin
                overrun_error_flag_ff <= 1'b0;
            end
            if (wr_mode) begin
                infrared_codec_enable_ff <= sw_mode[POS_IR];
                frame_format_select_ff <= sw_mode[POS_FMT_HI:POS_FMT_LO];
            end
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    usc_tx_state_type tx_state_ff;
    logic [CNT_W-1:0] tx_cnt_ff;
    logic [11:0] tx_shift_register_ff;
    logic [3:0] tx_left_ff;
    logic tx_par_ff, tx_paren_ff, tx_brk_ff;
    logic serial_tx_pin_ff, serial_tx_oe_ff, tx_irq_ff, rx_irq_ff;

    wire fmt_nine = frame_format_select_ff == FMT_9N;
    wire fmt_odd = frame_format_select_ff == FMT_8O;
    wire fmt_par = frame_format_select_ff == FMT_8E || fmt_odd;
    wire tx_idle = tx_state_ff == TX_IDLE;
    wire tx_tick = tx_cnt_ff == BIT_END;
    wire tx_brk_go = tx_idle && tx_enable_bit_ff && tx_break_request_ff;
    wire tx_load = tx_idle && tx_enable_bit_ff && !tx_break_request_ff && tx_count != '0;
    wire tx_last = tx_tick && tx_state_ff == TX_STOP;
    assign brk_done = tx_last && tx_brk_ff;
    assign tx_shift_empty = tx_idle && tx_count == '0;
    wire tx_level = (tx_state_ff == TX_START) ? 1'b0
        : (tx_state_ff == TX_DATA) ? tx_shift_register_ff[0]
        : (tx_state_ff == TX_PAR) ? tx_par_ff : 1'b1;
    // Zero bits become a short pulse at the start of the bit cell
    wire ir_on = !tx_level && tx_cnt_ff < IR_LEN;
    wire tx_out = infrared_codec_enable_ff
        ? (tx_polarity_invert_ff ? !ir_on : ir_on)
        : (tx_level ^ tx_polarity_invert_ff);
    wire tx_irq_hit = (tx_irq_mode_sel_ff == TXM_EACH && tx_load)
        || (tx_irq_mode_sel_ff == TXM_EMPTY && tx_load && tx_count == QW'(1) && !tx_push)
        || (tx_irq_mode_sel_ff == TXM_DONE && tx_last && tx_count == '0);

    usc_fifo #(.W(9), .D(FIFO_DEPTH)) u_tx_fifo (
        .clk(aclk),
        .rst_n(aresetn),
        .flush(!tx_enable_bit_ff),
        .push(tx_push),
        .din(s_axi_wdata[8:0]),
        .pop(tx_load),
        .head(tx_head),
        .count(tx_count)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn || !tx_enable_bit_ff) begin
            tx_state_ff <= TX_IDLE;
            tx_cnt_ff <= '0;
            tx_shift_register_ff <= 12'h000;
            tx_left_ff <= 4'h0;
            {tx_par_ff, tx_paren_ff, tx_brk_ff} <= 3'h0;
        end else begin
            tx_cnt_ff <= (tx_idle || tx_tick) ? '0 : CNT_W'(tx_cnt_ff + 1'b1);
            case (tx_state_ff)
                TX_IDLE: if (tx_brk_go || tx_load) begin
                    tx_state_ff <= TX_START;
                    tx_brk_ff <= tx_brk_go;
                    tx_shift_register_ff <= tx_brk_go ? 12'h000
                        : {3'h0, tx_head[8] && fmt_nine, tx_head[7:0]};
                    tx_left_ff <= tx_brk_go ? BREAK_BITS : (fmt_nine ? 4'h9 : 4'h8);
                    tx_par_ff <= (^tx_head[7:0]) ^ fmt_odd;
                    tx_paren_ff <= !tx_brk_go && fmt_par;
                end
                TX_START: if (tx_tick) tx_state_ff <= TX_DATA;
                TX_DATA: if (tx_tick) begin
                    tx_shift_register_ff <= tx_shift_register_ff >> 1;
                    tx_left_ff <= tx_left_ff - 4'h1;
                    if (tx_left_ff == 4'h1) tx_state_ff <= tx_paren_ff ? TX_PAR : TX_STOP;
                end
                TX_PAR: if (tx_tick) tx_state_ff <= TX_STOP;
                TX_STOP: if (tx_tick) tx_state_ff <= TX_IDLE;
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_tx_pin_ff <= 1'b1;
            serial_tx_oe_ff <= 1'b0;
            tx_irq_ff <= 1'b0;
        end else begin
            serial_tx_pin_ff <= tx_out;
            serial_tx_oe_ff <= tx_enable_bit_ff;
            tx_irq_ff <= tx_irq_hit;
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    usc_rx_state_type rx_state_ff;
    logic [CNT_W-1:0] rx_cnt_ff, ir_hold_ff;
    logic [8:0] rx_shift_register_ff;
    logic [3:0] rx_left_ff;
    logic rx_in_ff, rx_parbit_ff;

    // Decoder stretches each pulse to a full low bit
    wire rx_lvl = infrared_codec_enable_ff ? !(rx_in_ff || ir_hold_ff != '0) : rx_in_ff;
    wire rx_idle = rx_state_ff == RX_IDLE;
    wire rx_tick = rx_cnt_ff == BIT_END;
    wire rx_adv = (rx_state_ff == RX_START) ? rx_cnt_ff == BIT_HALF : rx_tick;
    wire rx_done = rx_tick && rx_state_ff == RX_STOP;
    wire [8:0] rx_data9 = fmt_nine ? rx_shift_register_ff : {1'b0, rx_shift_register_ff[8:1]};
    wire rx_parity_error_flag = fmt_par && ((^rx_data9[7:0]) ^ rx_parbit_ff ^ fmt_odd);
    wire rx_keep = !(address_detect_enable_ff && fmt_nine && !rx_data9[8]);
    wire rx_push = rx_done && rx_keep && !rx_full;
    assign rx_overrun = rx_done && rx_keep && rx_full;
    assign rx_idle_flag = rx_idle;
    wire rx_irq_hit = rx_push && (!rx_irq_mode_sel_ff[1]
        || rx_count == QW'(rx_irq_mode_sel_ff[0] ? FIFO_DEPTH - 1 : FIFO_DEPTH - 2));

    usc_fifo #(.W(RXW_W), .D(FIFO_DEPTH)) u_rx_fifo (
        .clk(aclk),
        .rst_n(aresetn),
        .flush(rx_flush),
        .push(rx_push),
        .din({rx_parity_error_flag, !rx_lvl, rx_data9}),
        .pop(rx_pop),
        .head(rx_head),
        .count(rx_count)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn || rx_flush) begin
            rx_state_ff <= RX_IDLE;
            rx_cnt_ff <= '0;
            rx_shift_register_ff <= 9'h000;
            rx_left_ff <= 4'h0;
            rx_parbit_ff <= 1'b0;
        end else begin
            rx_cnt_ff <= (rx_idle || rx_adv) ? '0 : CNT_W'(rx_cnt_ff + 1'b1);
            case (rx_state_ff)
                RX_IDLE: if (!rx_lvl) rx_state_ff <= RX_START;
                RX_START: if (rx_adv) begin
                    rx_state_ff <= rx_lvl ? RX_IDLE : RX_DATA;
                    rx_left_ff <= fmt_nine ? 4'h9 : 4'h8;
                end
                RX_DATA: if (rx_tick) begin
                    rx_shift_register_ff <= {rx_lvl, rx_shift_register_ff[8:1]};
                    rx_left_ff <= rx_left_ff - 4'h1;
                    if (rx_left_ff == 4'h1) rx_state_ff <= fmt_par ? RX_PAR : RX_STOP;
                end
                RX_PAR: if (rx_tick) begin
                    rx_parbit_ff <= rx_lvl;
                    rx_state_ff <= RX_STOP;
                end
                RX_STOP: if (rx_tick) rx_state_ff <= RX_IDLE;
                default: rx_state_ff <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_in_ff <= 1'b1;
            ir_hold_ff <= '0;
            rx_irq_ff <= 1'b0;
        end else begin
            rx_in_ff <= serial_rx_pin;
            ir_hold_ff <= rx_in_ff ? BIT_END : (ir_hold_ff != '0 ? CNT_W'(ir_hold_ff - 1'b1) : '0);
            rx_irq_ff <= rx_irq_hit;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = awready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign serial_tx_pin = serial_tx_pin_ff;
    assign serial_tx_oe = serial_tx_oe_ff;
    assign tx_irq_pulse = tx_irq_ff;
    assign rx_irq_pulse = rx_irq_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_tx_load_each;
        tx_load && tx_irq_mode_sel_ff == TXM_EACH;
    endsequence
    sequence s_ovr_release;
        ovr_clear && !rx_overrun;
    endsequence

    a_tx_irq_each: assert property (s_tx_load_each |=> tx_irq_pulse)
        else $error("transmit event missing on load");
    a_idle_plain: assert property ((tx_idle && !infrared_codec_enable_ff)
        |=> serial_tx_pin == !$past(tx_polarity_invert_ff))
        else $error("plain idle level wrong");
    a_idle_infrared: assert property ((tx_idle && infrared_codec_enable_ff)
        |=> serial_tx_pin == $past(tx_polarity_invert_ff))
        else $error("infrared idle level wrong");
    a_break_clear: assert property (brk_done |=> !status_word[POS_BRK])
        else $error("break request not cleared");
    a_tx_abort: assert property (!tx_enable_bit_ff
        |=> tx_idle && tx_count == '0 && !serial_tx_oe)
        else $error("disable did not abort transmitter");
    a_shift_empty: assert property (tx_push |=> !status_word[8])
        else $error("shift empty still set after write");
    a_rx_irq_three: assert property ((rx_push && !rx_pop && !rx_flush
        && rx_irq_mode_sel_ff == 2'h2 && rx_count == QW'(FIFO_DEPTH - 2))
        |=> rx_irq_pulse && rx_count == QW'(FIFO_DEPTH - 1))
        else $error("three-entry receive event wrong");
    a_ovr_flush: assert property (s_ovr_release
        |=> rx_count == '0 && rx_idle_flag && !overrun_error_flag_ff)
        else $error("overrun clear did not empty receiver");
    a_addr_drop: assert property ((rx_done && !rx_keep && !rx_pop && !rx_flush)
        |=> rx_count == $past(rx_count))
        else $error("data character stored in address mode");
    a_rx_avail: assert property ((rx_push && !rx_flush) |=> status_word[0])
        else $error("data available not set after store");
endmodule : usc_top
`default_nettype wire

// [hdl/usc_pkg.sv]
`default_nettype none
package usc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RXDATA = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Status and control field positions
    // ****************************************
    localparam int POS_TXM_HI = 15;
    localparam int POS_TXINV = 14;
    localparam int POS_TXM_LO = 13;
    localparam int POS_BRK = 11;
    localparam int POS_TXEN = 10;
    localparam int POS_RXM_HI = 7;
    localparam int POS_RXM_LO = 6;
    localparam int POS_ADET = 5;
    localparam int POS_OVR = 1;
    localparam logic [15:0] STATUS_RESET = 16'h0110;
    // ****************************************
    // Mode register fields and transmit event modes
    // ****************************************
    localparam int POS_IR = 12;
    localparam int POS_FMT_HI = 2;
    localparam int POS_FMT_LO = 1;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [1:0] FMT_8N = 2'h0;
    localparam logic [1:0] FMT_8E = 2'h1;
    localparam logic [1:0] FMT_8O = 2'h2;
    localparam logic [1:0] FMT_9N = 2'h3;
    localparam logic [1:0] TXM_EACH = 2'h0;
    localparam logic [1:0] TXM_DONE = 2'h1;
    localparam logic [1:0] TXM_EMPTY = 2'h2;
    // ****************************************
    // Receive word layout and timing
    // ****************************************
    localparam int RXW_W = 11;
    localparam int RXW_PARITY_ERROR_FLAG = 10;
    localparam int RXW_FRAMING_ERROR_FLAG = 9;
    localparam int FIFO_DEPTH_DEF = 4;
    localparam logic [3:0] BREAK_BITS = 4'hc;
    localparam int CLK_HZ = 25000000;
    localparam int BAUD_HZ = 115200;
    localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_HZ;
    localparam int IR_NUM = 3;
    localparam int IR_DEN = 16;

    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PAR = 5'b01000,
        TX_STOP = 5'b10000
    } usc_tx_state_type;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PAR = 5'b01000,
        RX_STOP = 5'b10000
    } usc_rx_state_type;
endpackage : usc_pkg
`default_nettype wire

// [hdl/usc_fifo.sv]
`default_nettype none
module usc_fifo #(
    parameter int W = 9,
    parameter int D = 4,
    localparam int CW = $clog2(D + 1)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic flush,
    input wire logic push,
    input wire logic [W-1:0] din,
    input wire logic pop,
    // State
    output logic [W-1:0] head,
    output logic [CW-1:0] count
);
    logic [W-1:0] mem_ff [D];
    logic [CW-1:0] count_ff;
    logic [CW-1:0] nxt_count;

    if (D < 2) begin : g_chk
        $error("usc_fifo depth below 2");
    end

    // Shift queue: entry 0 is always the head, so the head is a register
    wire do_pop = pop && count_ff != '0;
    wire do_push = push && (count_ff != CW'(D) || do_pop);
    wire [CW-1:0] wr_idx = do_pop ? CW'(count_ff - 1'b1) : count_ff;

    assign nxt_count = flush ? '0 : CW'(count_ff + CW'(do_push) - CW'(do_pop));
    assign head = mem_ff[0];
    assign count = count_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    for (genvar i = 0; i < D; i++) begin : g_ent
        wire [W-1:0] upper;
        if (i < D - 1) begin : g_up
            assign upper = mem_ff[i+1];
        end else begin : g_top
            assign upper = mem_ff[i];
        end
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                mem_ff[i] <= '0;
            end else if (do_push && wr_idx == CW'(i)) begin
                mem_ff[i] <= din;
            end else if (do_pop) begin
                mem_ff[i] <= upper;
            end
        end
    end
endmodule : usc_fifo
`default_nettype wire

// [verification/usc_node.sv]
`default_nettype none
module usc_node (
    // Link
    input wire logic clk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    // The line idles high, as it would with a pull-up fitted
    initial line = 1'b1;
    // Start bit, eight data bits LSB first, one stop bit, sixteen clocks per bit
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line <= f[i];
            repeat (16) @(posedge clk);
        end
    endtask : send
endmodule : usc_node
`default_nettype wire

// [verification/testbench.sv]
`default_nettype none
module testbench;
    import usc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
$display("Error %s expected %h seen %h", n, e, s); end end
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0] br, rr;
    logic awr, wrd, bv, arr, rv, txp, txoe, tirq, rirq, rxl;
    int err_total = 0, checked = 0, irqs = 0, tirqs = 0;
    usc_top #(.BIT_CYCLES(16)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h3),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .serial_rx_pin(rxl), .serial_tx_pin(txp), .serial_tx_oe(txoe), .tx_irq_pulse(tirq),
        .rx_irq_pulse(rirq));
    usc_node node (.clk(aclk), .line(rxl));
    initial forever #20 aclk = ~aclk;
    always @(posedge aclk) if (rirq === 1'b1) irqs++;
    always @(posedge aclk) if (tirq === 1'b1) tirqs++;
    task automatic tally_and_finish;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic hang;
        err_total++;
        tally_and_finish();
    endtask : hang
    // Ready and valid are read at the edge, before that edge's updates land
    // At least one edge passes, so a response still standing from the last call is not taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
        bit got = 1'b0;
        awa <= a;
        wd <= {16'h0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wrd === 1'b1) wv <= 1'b0;
            got = bv === 1'b1;
        end
        if (!got) hang();
        `CHK("bresp", e, br)
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        bit got = 1'b0;
        ara <= a;
        arv <= 1'b1;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 1'b0;
            got = rv === 1'b1;
        end
        if (!got) hang();
        `CHK("rdata", e, rdat)
        `CHK("rresp", er, rr)
    endtask : rc
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        `CHK("tx_idle", 1'b1, txp)
        rc(OFS_STATUS, 32'h0110, RESP_OKAY);
        rc(OFS_MODE, 32'h0, RESP_OKAY);
        rc(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 16'h0000, RESP_SLVERR);
        $display("reset test done");
    endtask : t_reset
    task automatic t_tx;
        logic [7:0] c;
        c = 8'h5a;
        wr(OFS_STATUS, 16'h2400, RESP_OKAY);
        wr(OFS_TXDATA, {8'h00, c}, RESP_OKAY);
        `CHK("tx_oe", 1'b1, txoe)
        for (int i = 0; i < 100 && txp !== 1'b0; i++) @(posedge aclk);
        if (txp !== 1'b0) hang();
        repeat (8) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge aclk);
            `CHK("tx_bit", c[i], txp)
        end
        rc(OFS_STATUS, 32'h2410, RESP_OKAY);
        `CHK("tx_irqs", 0, tirqs)
        repeat (40) @(posedge aclk);
        rc(OFS_STATUS, 32'h2510, RESP_OKAY);
        `CHK("tx_irqs", 1, tirqs)
        wr(OFS_STATUS, 16'h4400, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK("tx_idle", 1'b0, txp)
        // One character goes to the shifter, the other four fill the buffer
        for (int i = 0; i < 5; i++) wr(OFS_TXDATA, 16'h0011, RESP_OKAY);
        rc(OFS_STATUS, 32'h4610, RESP_OKAY);
        wr(OFS_STATUS, 16'h0000, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK("tx_oe", 1'b0, txoe)
        rc(OFS_STATUS, 32'h0110, RESP_OKAY);
        `CHK("tx_irqs", 2, tirqs)
        $display("transmit test done");
    endtask : t_tx
    task automatic t_rx;
        wr(OFS_STATUS, 16'h00c0, RESP_OKAY);
        for (int i = 0; i < 4; i++) node.send(8'ha1 + 8'(i));
        `CHK("rx_irqs", 1, irqs)
        rc(OFS_STATUS, 32'h01d1, RESP_OKAY);
        node.send(8'h33);
        rc(OFS_STATUS, 32'h01d3, RESP_OKAY);
        rc(OFS_RXDATA, 32'h00a1, RESP_OKAY);
        wr(OFS_STATUS, 16'h00c0, RESP_OKAY);
        rc(OFS_STATUS, 32'h01d0, RESP_OKAY);
        // Even parity: the partner's stop bit lands in the parity cell, which is wrong for 0x33
        wr(OFS_MODE, 16'h0002, RESP_OKAY);
        node.send(8'h33);
        repeat (20) @(posedge aclk);
        rc(OFS_STATUS, 32'h01d9, RESP_OKAY);
        rc(OFS_RXDATA, 32'h0033, RESP_OKAY);
        rc(OFS_STATUS, 32'h01d0, RESP_OKAY);
        $display("receive test done");
    endtask : t_rx
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_tx();
        t_rx();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
